/* fm_disc_pkg.sv */
/*
 * Constants, register map and carrier types for the digital FM
 * discriminator block.
 * Assumes: one 20 MHz clock, APB slave with 8-bit byte addresses.
 */
// Notes on behaviour
// - square IF input into clean one-bit logic
// - mixed path samples at bus clock over two
// - mixed-down output carries the sampled input directly
// - discriminator samples at crystal divided by D
// - only one bit kept per sample
// - output is sample XOR sample M earlier
// - delay counted in crystal-derived sample periods
// - normal command 01: second-byte bit5 powers discriminator
// - setup 10xxxxxx/xx1xxx00 loads D and M select
// - select 00,10,01,11 give D/M 2/39,3/40,3/37,2/38
// - setup also loads lock filter and oscillator mode
// - discriminator output is full-swing logic
package fm_disc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OFS_CMD    = 8'h00; // command write
    localparam logic [7:0] OFS_STATUS = 8'h04; // settings and state
    localparam logic [7:0] OFS_DATA   = 8'h08; // packed output pop

    // status field positions
    localparam int ST_SEL_LSB  = 0;
    localparam int ST_LOCK     = 2;
    localparam int ST_OSC_LSB  = 3;
    localparam int ST_POWER    = 6;
    localparam int ST_CNT_LSB  = 8;
    localparam int ST_LOST     = 16;

    // ************************************************************
    // command decode constants
    // ************************************************************
    localparam logic [1:0] OP_NORMAL    = 2'h1;
    localparam logic [1:0] OP_SETUP     = 2'h2;
    localparam int         BIT_POWER    = 5;
    localparam int         BIT_DISCSEL  = 5; // third-byte marker bit
    localparam logic [1:0] SETUP_LOW    = 2'h0;

    // reset values
    localparam logic [1:0] RST_SEL   = 2'h0;
    localparam logic [2:0] RST_OSC   = 3'h6;
    localparam logic       RST_LOCK  = 1'h0;
    localparam logic       RST_POWER = 1'h0;

    // divider and delay per select code {bit7,bit6}
    localparam logic [1:0] D_SEL00 = 2'h2;
    localparam logic [1:0] D_SEL10 = 2'h3;
    localparam logic [1:0] D_SEL01 = 2'h3;
    localparam logic [1:0] D_SEL11 = 2'h2;
    localparam logic [5:0] M_SEL00 = 6'h27; // 39
    localparam logic [5:0] M_SEL10 = 6'h28; // 40
    localparam logic [5:0] M_SEL01 = 6'h25; // 37
    localparam logic [5:0] M_SEL11 = 6'h26; // 38
    localparam int         M_MAX   = 40;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [1:0] sel;      // divider/delay select
        logic       lockFilt; // lock logic filter period
        logic [2:0] oscMode;  // clock oscillator mode
    } setup_t;

    typedef struct packed {
        logic [1:0] d;
        logic [5:0] m;
    } divdelay_t;

endpackage : fm_disc_pkg

/* fifo_buf.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes: single clock, synchronous active-high reset.
 */
module fifo_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output      logic             inReady,
    output      logic [WIDTH-1:0] outData,
    output      logic             outValid,
    input  wire logic             outReady,
    output      logic [CW-1:0]    count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [CW-1:0]    cnt_ff;
    wire              doPush;
    wire              doPop;

    // honest flags come straight from the occupancy count
    assign inReady  = (cnt_ff != CW'(DEPTH));
    assign outValid = (cnt_ff != '0);
    assign outData  = mem_ff[rdPtr_ff];
    assign count    = cnt_ff;
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    // pointer wrap helper, depth need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    // pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            cnt_ff   <= '0;
        end else begin
            if (doPush) wrPtr_ff <= bump(wrPtr_ff);
            if (doPop) rdPtr_ff <= bump(rdPtr_ff);
            cnt_ff <= CW'(cnt_ff + CW'(doPush) - CW'(doPop));
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (doPush) mem_ff[wrPtr_ff] <= inData;
    end

    AST_FIFO_NOOVER: assert property (@(posedge clk) disable iff (rst)
        cnt_ff <= CW'(DEPTH))
        else $error("fifo count above depth");
endmodule : fifo_buf

/* fm_discriminator.sv */
/*
 * Digital FM quadrature discriminator with mixed-down IF path,
 * command decoder and APB register access.
 * Assumes: clk stands for the crystal clock; IF input and bus clock
 * are level inputs sampled by clk; APB master per the AMBA protocol.
 */
module fm_discriminator #(
    parameter int LINE_LEN   = fm_disc_pkg::M_MAX,
    parameter int FIFO_DEPTH = 8,
    parameter int WORD_W     = 32
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ifLimitedInput,
    input  wire logic        chipsetBusClock,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    output      logic        mixedDownOutput,
    output      logic        discOutput
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // ************************************************************
    // input squaring and synchronisers
    // ************************************************************
    logic ifMeta_ff, ifSync_ff, ifHold_ff, sq_ff;
    logic cbMeta_ff, cbSync_ff, cbLast_ff;

    // first stage feeds only the second; hysteresis needs two agreeing
    // samples so a slow or noisy edge cannot chatter
    always_ff @(posedge clk) begin
        if (rst) begin
            ifMeta_ff <= 1'b0;
            ifSync_ff <= 1'b0;
            ifHold_ff <= 1'b0;
            sq_ff     <= 1'b0;
        end else begin
            ifMeta_ff <= ifLimitedInput;
            ifSync_ff <= ifMeta_ff;
            ifHold_ff <= ifSync_ff;
            if (ifSync_ff == ifHold_ff) sq_ff <= ifHold_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cbMeta_ff <= 1'b0;
            cbSync_ff <= 1'b0;
            cbLast_ff <= 1'b0;
        end else begin
            cbMeta_ff <= chipsetBusClock;
            cbSync_ff <= cbMeta_ff;
            cbLast_ff <= cbSync_ff;
        end
    end

    // ************************************************************
    // mixed-down path
    // ************************************************************
    logic halfDiv_ff, mix_ff;
    wire  cbRise   = cbSync_ff & ~cbLast_ff;
    wire  mixTick  = cbRise & halfDiv_ff;

    // every second bus clock rise takes one sample
    always_ff @(posedge clk) begin
        if (rst) begin
            halfDiv_ff <= 1'b0;
            mix_ff     <= 1'b0;
        end else begin
            if (cbRise) halfDiv_ff <= ~halfDiv_ff;
            if (mixTick) mix_ff <= sq_ff;
        end
    end
    assign mixedDownOutput = mix_ff;

    // ************************************************************
    // command state
    // ************************************************************
    fm_disc_pkg::setup_t setup_ff;
    logic                power_ff;
    wire                 apbDone = psel & penable & pready;
    wire                 isCmd   = (paddr == fm_disc_pkg::OFS_CMD);
    wire                 isStat  = (paddr == fm_disc_pkg::OFS_STATUS);
    wire                 isData  = (paddr == fm_disc_pkg::OFS_DATA);
    wire                 cmdWr   = apbDone & pwrite & isCmd;
    wire [7:0]           byte1   = pwdata[7:0];
    wire [7:0]           byte2   = pwdata[15:8];
    wire [7:0]           byte3   = pwdata[23:16];
    // other opcodes drive functions outside this block and are ignored
    wire isNormal = cmdWr & (byte2[7:6] == fm_disc_pkg::OP_NORMAL);
    wire isSetup  = cmdWr & (byte2[7:6] == fm_disc_pkg::OP_SETUP)
                  & byte3[fm_disc_pkg::BIT_DISCSEL]
                  & (byte3[1:0] == fm_disc_pkg::SETUP_LOW);

    // command bytes land in the state only on a completed write
    always_ff @(posedge clk) begin
        if (rst) begin
            setup_ff.sel      <= fm_disc_pkg::RST_SEL;
            setup_ff.lockFilt <= fm_disc_pkg::RST_LOCK;
            setup_ff.oscMode  <= fm_disc_pkg::RST_OSC;
            power_ff          <= fm_disc_pkg::RST_POWER;
        end else begin
            if (isNormal) power_ff <= byte2[fm_disc_pkg::BIT_POWER];
            if (isSetup) begin
                setup_ff.sel      <= byte1[7:6];
                setup_ff.lockFilt <= byte1[5];
                setup_ff.oscMode  <= byte1[2:0];
            end
        end
    end

    // ************************************************************
    // divider, delay line and exclusive-OR
    // ************************************************************
    // one table serves both the sample divider and the delay tap
    function automatic fm_disc_pkg::divdelay_t decode(input logic [1:0] s);
        case (s)
            2'h0:    decode = '{fm_disc_pkg::D_SEL00, fm_disc_pkg::M_SEL00};
            2'h2:    decode = '{fm_disc_pkg::D_SEL10, fm_disc_pkg::M_SEL10};
            2'h1:    decode = '{fm_disc_pkg::D_SEL01, fm_disc_pkg::M_SEL01};
            default: decode = '{fm_disc_pkg::D_SEL11, fm_disc_pkg::M_SEL11};
        endcase
    endfunction : decode

    fm_disc_pkg::divdelay_t dm;
    logic [1:0]          divCnt_ff;
    logic [LINE_LEN-1:0] line_ff;
    logic                disc_ff;
    assign dm = decode(setup_ff.sel);
    wire  sampEn  = (divCnt_ff == 2'(dm.d - 2'h1));
    wire  tapBit  = line_ff[6'(dm.m - 6'h1)];
    wire  xorBit  = sq_ff ^ tapBit;

    // sample clock and delay both count crystal periods, so the
    // comparison span never wanders
    always_ff @(posedge clk) begin
        if (rst) divCnt_ff <= '0;
        else divCnt_ff <= sampEn ? 2'h0 : 2'(divCnt_ff + 2'h1);
    end

    // one bit per sample; powered down holds output low
    always_ff @(posedge clk) begin
        if (rst) begin
            line_ff <= '0;
            disc_ff <= 1'b0;
        end else if (!power_ff) begin
            disc_ff <= 1'b0;
        end else if (sampEn) begin
            line_ff <= {line_ff[LINE_LEN-2:0], sq_ff};
            disc_ff <= xorBit;
        end
    end
    assign discOutput = disc_ff; // full logic swing

    // ************************************************************
    // output packer and FIFO
    // ************************************************************
    localparam int PW = $clog2(WORD_W);
    logic [WORD_W-1:0] pack_ff;
    logic [PW-1:0]     packCnt_ff;
    logic              packFull_ff, lost_ff;
    // head-valid as it stood when read data was latched; popping on the
    // live flag would drop a word pushed during the access phase
    logic              dataOk_ff;
    logic              inReady, outValid;
    logic [WORD_W-1:0] outData;
    logic [CW-1:0]     fifoCnt;
    wire               takeBit = power_ff & sampEn;
    wire               popData = apbDone & ~pwrite & isData & dataOk_ff;
    wire               statRd  = apbDone & ~pwrite & isStat;

    // a full word waits for FIFO space; bits arriving meanwhile are
    // dropped and flagged, which beats stalling the sample clock
    always_ff @(posedge clk) begin
        if (rst) begin
            pack_ff     <= '0;
            packCnt_ff  <= '0;
            packFull_ff <= 1'b0;
            lost_ff     <= 1'b0;
        end else begin
            if (packFull_ff && inReady) packFull_ff <= 1'b0;
            // the word leaves in a push cycle, so that cycle's bit still fits
            if (takeBit && (!packFull_ff || inReady)) begin
                pack_ff    <= {pack_ff[WORD_W-2:0], xorBit};
                packCnt_ff <= PW'(packCnt_ff + 1'b1);
                if (packCnt_ff == PW'(WORD_W - 1)) packFull_ff <= 1'b1;
            end
            // set wins over the read-clear
            if (takeBit && packFull_ff && !inReady) lost_ff <= 1'b1;
            else if (statRd) lost_ff <= 1'b0;
        end
    end

    fifo_buf #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inData   (pack_ff),
        .inValid  (packFull_ff),
        .inReady  (inReady),
        .outData  (outData),
        .outValid (outValid),
        .outReady (popData),
        .count    (fifoCnt)
    );

    // ************************************************************
    // APB slave: one wait state on every access
    // ************************************************************
    logic        pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] statWord;
    logic [31:0] rdMux;
    wire         mapped = isCmd | isStat | isData;

    always_comb begin
        statWord = '0;
        statWord[fm_disc_pkg::ST_SEL_LSB +: 2] = setup_ff.sel;
        statWord[fm_disc_pkg::ST_LOCK]         = setup_ff.lockFilt;
        statWord[fm_disc_pkg::ST_OSC_LSB +: 3] = setup_ff.oscMode;
        statWord[fm_disc_pkg::ST_POWER]        = power_ff;
        statWord[fm_disc_pkg::ST_CNT_LSB +: CW] = fifoCnt;
        statWord[fm_disc_pkg::ST_LOST]         = lost_ff;
    end
    assign rdMux = isStat ? statWord :
                   (isData && outValid) ? outData : 32'h0000_0000;

    // ready rises in the second access cycle, read data with it
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            dataOk_ff  <= 1'b0;
        end else begin
            pready_ff  <= psel & penable & ~pready_ff;
            dataOk_ff  <= isData & outValid;
            pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
            prdata_ff  <= (psel & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // ************************************************************
    // checks
    // ************************************************************
    // all assertions run on the one crystal clock and drop out in reset
    AST_MIX_TRACK: assert property (@(posedge clk) disable iff (rst)
        mixTick |=> mix_ff == $past(sq_ff))
        else $error("mixed output missed its sample");
    AST_MIX_HALF: assert property (@(posedge clk) disable iff (rst)
        cbRise && !halfDiv_ff |=> $stable(mix_ff))
        else $error("mixed output sampled on odd bus edge");
    // a setup landing mid-count may bend one gap, so demand a steady select
    AST_SAMP_PERIOD: assert property (@(posedge clk) disable iff (rst)
        sampEn && dm.d == 2'h3 ##1 $stable(setup_ff.sel)
        ##1 $stable(setup_ff.sel) ##1 $stable(setup_ff.sel)
        |-> sampEn && !$past(sampEn) && !$past(sampEn, 2))
        else $error("sample period not D");
    AST_XOR: assert property (@(posedge clk) disable iff (rst)
        power_ff && sampEn && $stable(power_ff)
        |=> disc_ff == ($past(sq_ff) ^ $past(tapBit)))
        else $error("discriminator output not xor of taps");
    AST_DELAY: assert property (@(posedge clk) disable iff (rst)
        power_ff && sampEn |=> line_ff[0] == $past(sq_ff)
            && line_ff[1] == $past(line_ff[0]))
        else $error("delay line did not take one sample");
    // the line moves only on sample enables, so the span is D*M crystals
    AST_LINE_HOLD: assert property (@(posedge clk) disable iff (rst)
        !sampEn |=> $stable(line_ff))
        else $error("delay line moved between samples");
    AST_POWER_OFF: assert property (@(posedge clk) disable iff (rst)
        isNormal && !byte2[fm_disc_pkg::BIT_POWER] |=> ##1 !disc_ff)
        else $error("discriminator active after power down");
    AST_SETUP_LOAD: assert property (@(posedge clk) disable iff (rst)
        isSetup |=> setup_ff.sel == $past(byte1[7:6]))
        else $error("setup command did not load select");
    AST_DECODE: assert property (@(posedge clk) disable iff (rst)
        setup_ff.sel == 2'h2 |-> dm.d == 2'h3 && dm.m == 6'h28)
        else $error("select 10 decode wrong");
    AST_OSC_LOAD: assert property (@(posedge clk) disable iff (rst)
        isSetup |=> setup_ff.oscMode == $past(byte1[2:0])
                    && setup_ff.lockFilt == $past(byte1[5]))
        else $error("setup side bits not loaded");
    AST_SEL_HOLD: assert property (@(posedge clk) disable iff (rst)
        !isSetup |=> $stable(setup_ff.sel))
        else $error("select changed without setup");
    AST_SQ_STABLE: assert property (@(posedge clk) disable iff (rst)
        $changed(sq_ff) |-> $past(ifSync_ff) == $past(ifHold_ff))
        else $error("squared input changed without agreement");

    // main scenarios: setup, power-up sampling, FIFO full, pop, loss
    COV_SETUP:   cover property (@(posedge clk) isSetup);
    COV_POWERON: cover property (@(posedge clk) isNormal ##[1:20] sampEn);
    COV_FULL:    cover property (@(posedge clk) !inReady);
    COV_POP:     cover property (@(posedge clk) popData);
    COV_LOST:    cover property (@(posedge clk) lost_ff);
endmodule : fm_discriminator

/* if_limiter_model.sv */
/*
 * Model of the IF limiting amplifier that drives the squared IF input:
 * a steady level, a square wave, or one-cycle pulses on a level.
 * Assumes: one clock; every change lands just after a rising edge.
 */
module if_limiter_model (
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] halfPeriod,
    input  wire logic       level,
    output      logic       ifOut
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] halfCnt_ff;

    initial ifOut = 1'b0;
    initial halfCnt_ff = 8'h00;

    // mode 0 level, 1 square of halfPeriod cycles, 2 pulses every 8
    // pulses are one cycle wide so the input hysteresis must drop them
    always @(posedge clk) begin
        halfCnt_ff <= halfCnt_ff + 8'h01;
        if (mode == 2'h1) begin
            if (halfCnt_ff + 8'h01 >= halfPeriod) begin
                halfCnt_ff <= 8'h00;
                ifOut      <= ~ifOut;
            end
        end else if (mode == 2'h2) begin
            ifOut <= (halfCnt_ff[2:0] == 3'h0) ? ~level : level;
        end else begin
            ifOut <= level;
        end
    end
endmodule : if_limiter_model

/* digital_fm_discriminator_tb.sv */
/*
 * Self-checking bench for the FM discriminator: APB master, command
 * decode, FIFO fill and drain, delay line and mixed-down path.
 * Assumes: the IF limiter model beside it; bus clock made here.
 */
`define CHK(nm, ex, gt) \
    begin checked++; if ((gt) !== (ex)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
    mismatches++; end end

module digital_fm_discriminator_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, halfPeriod;
    logic [31:0] pwdata, prdata, rdv, lfsrState;
    logic        mixedDownOutput, discOutput, ifLimitedInput;
    logic        erv, holdOk, srcLevel;
    logic [1:0]  srcMode;
    logic [2:0]  busCnt_ff;
    logic [1:0]  sels [5];
    int          mismatches, checked, cycles, hp;

    fm_discriminator dut_u (
        .clk(clk), .rst(rst), .ifLimitedInput(ifLimitedInput),
        .chipsetBusClock(busCnt_ff[2]), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mixedDownOutput(mixedDownOutput),
        .discOutput(discOutput));

    if_limiter_model src_u (
        .clk(clk), .mode(srcMode), .halfPeriod(halfPeriod),
        .level(srcLevel), .ifOut(ifLimitedInput));

    // ************************************************************
    // clock, bus clock, timeout
    // ************************************************************
    always #25 clk = ~clk;

    // bus clock at clk/8, well below the clk/2 limit
    always @(posedge clk) begin
        busCnt_ff <= busCnt_ff + 3'h1;
    end

    // a hung handshake ends the run here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            mismatches++;
            complete_run();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [31:0] setup_word(input logic [1:0] s,
                                              input logic lk,
                                              input logic [2:0] o);
        return {8'h00, 8'h20, 8'h80, s, lk, 2'h0, o};
    endfunction : setup_word

    function automatic logic [31:0] power_word(input logic p);
        return {16'h0000, 2'h1, p, 5'h00, 8'h00};
    endfunction : power_word

    function automatic logic [6:0] st_exp(input logic [1:0] s,
                                          input logic lk,
                                          input logic [2:0] o,
                                          input logic p);
        return {p, o, lk, s};
    endfunction : st_exp

    // compare distance D*M in clk cycles per select code
    function automatic int delay_of(input logic [1:0] s);
        case (s)
            2'h0:    return 78;
            2'h2:    return 120;
            2'h1:    return 111;
            default: return 76;
        endcase
    endfunction : delay_of

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // level of one output over n edges; sets holdOk
    task automatic watch(input logic useMixed, input logic expV,
                         input int n);
        holdOk = 1'b1;
        repeat (n) begin
            @(posedge clk);
            if ((useMixed ? mixedDownOutput : discOutput) !== expV)
                holdOk = 1'b0;
        end
    endtask : watch

    task complete_run;
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        busCnt_ff = 3'h0; srcMode = 2'h0; srcLevel = 1'b0;
        halfPeriod = 8'h4E; lfsrState = 32'hF07C;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        `CHK("disc reset", 1'b0, discOutput)
        rd(fm_disc_pkg::OFS_STATUS);
        `CHK("status reset", st_exp(2'h0, 1'b0, 3'h6, 1'b0), rdv[6:0])
        `CHK("mapped err", 1'b0, erv)
        rd(8'h0C);
        `CHK("unmapped err", 1'b1, erv)
        `CHK("unmapped data", 32'h0000_0000, rdv)
        // random commands that are neither normal nor setup
        for (int i = 0; i < 6; i++) begin
            lfsrState = lfsr_next(lfsrState);
            apb(1'b1, fm_disc_pkg::OFS_CMD,
                {lfsrState[31:16], {2{lfsrState[14]}}, lfsrState[13:0]});
            rd(fm_disc_pkg::OFS_STATUS);
            `CHK("ignored cmd", st_exp(2'h0, 1'b0, 3'h6, 1'b0), rdv[6:0])
        end
        apb(1'b1, fm_disc_pkg::OFS_CMD, 32'h0000_80E7);
        apb(1'b1, fm_disc_pkg::OFS_CMD, 32'h0021_80E7);
        rd(fm_disc_pkg::OFS_STATUS);
        `CHK("bad setup", st_exp(2'h0, 1'b0, 3'h6, 1'b0), rdv[6:0])
        // fill the FIFO until bits are lost; words are all-ones from the third on
        srcMode <= 2'h1;
        apb(1'b1, fm_disc_pkg::OFS_CMD, power_word(1'b1));
        repeat (1200) @(posedge clk);
        rd(fm_disc_pkg::OFS_STATUS);
        `CHK("fifo full", 4'h8, rdv[11:8])
        `CHK("lost set", 1'b1, rdv[16])
        apb(1'b1, fm_disc_pkg::OFS_CMD, power_word(1'b0));
        rd(fm_disc_pkg::OFS_STATUS);
        rd(fm_disc_pkg::OFS_STATUS);
        `CHK("lost clear", 1'b0, rdv[16])
        for (int k = 0; k < 8; k++) begin
            rd(fm_disc_pkg::OFS_DATA);
            if (k >= 2) `CHK("fifo word", 32'hFFFF_FFFF, rdv)
        end
        for (int k = 0; k < 3; k++) begin
            rd(fm_disc_pkg::OFS_STATUS);
            if (rdv[11:8] != 4'h0) rd(fm_disc_pkg::OFS_DATA);
        end
        rd(fm_disc_pkg::OFS_DATA);
        `CHK("empty pop", 32'h0000_0000, rdv)
        // every select code; first entry compares a whole period
        sels = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h3};
        apb(1'b1, fm_disc_pkg::OFS_CMD, power_word(1'b1));
        for (int i = 0; i < 5; i++) begin
            lfsrState = lfsr_next(lfsrState);
            apb(1'b1, fm_disc_pkg::OFS_CMD,
                setup_word(sels[i], lfsrState[3], lfsrState[2:0]));
            rd(fm_disc_pkg::OFS_STATUS);
            `CHK("setup", st_exp(sels[i], lfsrState[3], lfsrState[2:0], 1'b1), rdv[6:0])
            // with D=3 a third of the delay keeps the IF off the sample
            // harmonics, and three half periods still give a steady one
            hp = (i == 0) ? delay_of(sels[i]) / 2 :
                 (i == 2 || i == 3) ? delay_of(sels[i]) / 3 :
                 delay_of(sels[i]);
            halfPeriod <= 8'(hp);
            repeat (300) @(posedge clk);
            watch(1'b0, (i != 0), 200);
            `CHK("disc level", 1'b1, holdOk)
        end
        apb(1'b1, fm_disc_pkg::OFS_CMD, power_word(1'b0));
        repeat (10) @(posedge clk);
        watch(1'b0, 1'b0, 100);
        `CHK("disc off", 1'b1, holdOk)
        // mixed-down path follows steady levels, ignores pulses
        srcMode  <= 2'h0;
        srcLevel <= 1'b1;
        repeat (100) @(posedge clk);
        watch(1'b1, 1'b1, 40);
        `CHK("mixed high", 1'b1, holdOk)
        srcLevel <= 1'b0;
        repeat (100) @(posedge clk);
        watch(1'b1, 1'b0, 40);
        `CHK("mixed low", 1'b1, holdOk)
        srcMode <= 2'h2;
        watch(1'b1, 1'b0, 200);
        `CHK("pulse reject", 1'b1, holdOk)
        complete_run();
    end
endmodule : digital_fm_discriminator_tb
